/* File: dv/dac_input_frame_decode_trim_regs_bench.sv */
// Purpose: Frame level tests of the decoder
// Assumes: Straps and clear pin change at falling clk
// Notes: Expectations kept per channel in the bench
module dac_input_frame_decode_trim_regs_bench;
  import dfd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clear_pin = 1'b0;
  logic [1:0] strap = 2'h2;
  logic ce = 1'b1;
  logic sclk, sync_n, sdin, ctl_wr, frame_seen;
  logic [63:0] gain_trim, offset_trim, clear_value, dac_data;
  logic [3:0] clear_active;
  logic [3:0] en = 4'h0;
  logic [2:0] ctl_select;
  logic [1:0] ctl_channel;
  logic [12:0] ctl_data;
  dfd_word_t eg[4] = '{4{16'hFFFF}};
  dfd_word_t eo[4] = '{4{16'h8000}};
  dfd_word_t ec[4] = '{4{16'h0000}};
  dfd_word_t ed[4] = '{4{16'h0000}};
  int error_cnt = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  dfd_host_model host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
  dfd_frame_decode #(.CHANNELS(4)) DUT (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk),
    .sync_n(sync_n), .sdin(sdin), .address_strap_hi(strap[1]), .address_strap_lo(strap[0]),
    .clear_pin(clear_pin), .gain_trim(gain_trim), .offset_trim(offset_trim),
    .clear_value(clear_value), .dac_data(dac_data), .clear_active(clear_active),
    .ctl_wr(ctl_wr), .ctl_select(ctl_select), .ctl_channel(ctl_channel),
    .ctl_data(ctl_data), .frame_seen(frame_seen));
  ////////////////////////////////////////////////////////////////
  // Compare one value
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // Compare all trim, clear and data registers
  task automatic regs();
    chk(gain_trim, {eg[3], eg[2], eg[1], eg[0]});
    chk(offset_trim, {eo[3], eo[2], eo[1], eo[0]});
    chk(clear_value, {ec[3], ec[2], ec[1], ec[0]});
    chk(dac_data, {ed[3], ed[2], ed[1], ed[0]});
  endtask : regs
  // Send a frame, track the expectation, count the pulses
  task automatic frame(input logic rw, input logic [1:0] dev, input logic [2:0] sel,
    input logic [1:0] ch, input dfd_word_t d, input int nbits);
    logic hit;
    int seen;
    int wrs;
    hit = (nbits == 24) && (dev == strap);
    seen = 0;
    wrs = 0;
    host.send({rw, dev, sel, ch, d}, nbits);
    for (int i = 0; i < 24; i++) begin
      @(negedge clk);
      seen += (frame_seen !== 1'b0);
      wrs += (ctl_wr !== 1'b0);
    end
    if (hit && !rw) begin
      case (sel)
        3'h0: ed[ch] = d;
        3'h2: eg[ch] = d;
        3'h3: eg = '{d, d, d, d};
        3'h4: eo[ch] = d;
        3'h5: eo = '{d, d, d, d};
        3'h6: ec[ch] = d;
        3'h7: if (d[15:13] == 3'h4) en = d[3:0];
        default: ;
      endcase
    end
    chk(64'(seen), 64'(hit));
    chk(64'(wrs), 64'(hit && !rw && sel == 3'h7));
    if (hit && !rw && sel == 3'h7) begin
      chk(64'({ctl_select, ctl_channel, ctl_data}), 64'({d[15:13], ch, d[12:0]}));
    end
    regs();
  endtask : frame
  // Raise the clear pin and compare the gated channels
  task automatic clear_test();
    clear_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk(64'(clear_active), 64'(en));
    clear_pin = 1'b0;
    repeat (8) @(negedge clk);
  endtask : clear_test
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    regs();
    chk(64'(clear_active), 64'h0);
    $display("Test reset done");
    foreach (ed[c]) begin
      for (int s = 0; s < 8; s += 2) begin
        frame(1'b0, 2'h2, 3'(s), 2'(c), 16'(c * 16'h1111 + 1), 24);
      end
    end
    $display("Test single channel done");
    frame(1'b0, 2'h2, 3'h3, 2'h1, 16'h8000, 24);
    frame(1'b0, 2'h2, 3'h5, 2'h2, 16'hFFFF, 24);
    $display("Test broadcast done");
    frame(1'b1, 2'h2, 3'h2, 2'h0, 16'h5A5A, 24);
    frame(1'b0, 2'h1, 3'h2, 2'h0, 16'h5A5A, 24);
    frame(1'b0, 2'h2, 3'h2, 2'h0, 16'h5A5A, 23);
    frame(1'b0, 2'h2, 3'h1, 2'h0, 16'h5A5A, 24);
    $display("Test refused frames done");
    clear_test();
    frame(1'b0, 2'h2, 3'h7, 2'h2, 16'h8005, 24);
    frame(1'b0, 2'h2, 3'h7, 2'h1, 16'h2ABC, 24);
    clear_test();
    $display("Test control and clear done");
    strap = 2'h1;
    repeat (4) @(negedge clk);
    frame(1'b0, 2'h2, 3'h2, 2'h3, 16'h1357, 24);
    frame(1'b0, 2'h1, 3'h2, 2'h3, 16'h7FFF, 24);
    $display("Test strap change done");
    // Clock enable low freezes decode; the held frame lands once it returns
    ce = 1'b0;
    host.send({1'b0, 2'h1, 3'h4, 2'h0, 16'h4321}, 24);
    repeat (24) @(negedge clk);
    chk(64'(frame_seen), 64'h0);
    regs();
    ce = 1'b1;
    repeat (24) @(negedge clk);
    eo[0] = 16'h4321;
    regs();
    $display("Test clock enable done");
    tally_and_finish();
  end
endmodule : dac_input_frame_decode_trim_regs_bench

/* File: dv/dfd_frame_decode_chk.sv */
// Purpose: Port checks on the frame decoder
// Assumes: Synchronous active high reset on clk
// Notes: Broadcast checks assume four channels
module dfd_chk
  import dfd_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear_pin,
  input wire logic [16*CHANNELS-1:0] gain_trim,
  input wire logic [16*CHANNELS-1:0] offset_trim,
  input wire logic [16*CHANNELS-1:0] clear_value,
  input wire logic [16*CHANNELS-1:0] dac_data,
  input wire logic [CHANNELS-1:0] clear_active,
  input wire logic ctl_wr,
  input wire logic frame_seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Defaults right after reset
  reset_values_a: assert property ($past(rst) |-> gain_trim == {CHANNELS{16'hFFFF}}
    && offset_trim == {CHANNELS{16'h8000}} && clear_value == '0 && clear_active == '0)
    else $error("Bad reset values");
  reg_quiet_a: assert property ((!$stable(gain_trim) || !$stable(offset_trim)
    || !$stable(clear_value) || !$stable(dac_data)) |-> (frame_seen || $past(frame_seen)))
    else $error("Register changed without a frame");
  gain_bcast_a: assert property ((!$stable(gain_trim[15:0]) && !$stable(gain_trim[31:16]))
    |-> gain_trim == {CHANNELS{gain_trim[15:0]}}) else $error("Gain broadcast mismatch");
  ofs_bcast_a: assert property ((!$stable(offset_trim[15:0]) && !$stable(offset_trim[31:16]))
    |-> offset_trim == {CHANNELS{offset_trim[15:0]}}) else $error("Offset broadcast mismatch");
  ctl_frame_a: assert property (ctl_wr |-> frame_seen || $past(frame_seen))
    else $error("Control write without a frame");
  ctl_once_a: assert property (ctl_wr |=> !ctl_wr)
    else $error("Control strobe too long");
  seen_once_a: assert property (frame_seen |=> !frame_seen)
    else $error("Frame pulse too long");
  clr_gate_a: assert property (clear_active != '0 |-> $past(clear_pin)
    || $past(clear_pin, 2) || $past(clear_pin, 3) || $past(clear_pin, 4))
    else $error("Clear active without clear pin");
  // Main scenarios
  cover property (ctl_wr);
  cover property (clear_active != '0);
  cover property (!$stable(gain_trim[15:0]) && !$stable(gain_trim[63:48]));
endmodule : dfd_chk
bind dfd_frame_decode dfd_chk #(.CHANNELS(CHANNELS)) u_chk (.clk(clk), .rst(rst),
  .clear_pin(clear_pin), .gain_trim(gain_trim), .offset_trim(offset_trim),
  .clear_value(clear_value), .dac_data(dac_data), .clear_active(clear_active),
  .ctl_wr(ctl_wr), .frame_seen(frame_seen));

/* File: dv/dfd_host_model.sv */
// Purpose: Controller model driving the serial write link
// Assumes: Link clock idles high; bits change while it is high
// Notes: Released data line shows the inverse of the last bit
module dfd_host_model
  import dfd_pkg::*;
(
  output logic sclk,
  output logic sync_n,
  output logic sdin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle link, clock stands still
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  // Shift the top nbits of a frame, MSB first, then close the frame
  task automatic send(input dfd_frame_t f, input int nbits);
    #13.7 sync_n = 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      sdin = f[i];
      #40 sclk = 1'b0;
      #40 sclk = 1'b1;
    end
    #40 sync_n = 1'b1;
    sdin = ~sdin;
  endtask : send
endmodule : dfd_host_model

/* File: rtl/dfd_defines.svh */
`ifndef DFD_DEFINES_SVH
`define DFD_DEFINES_SVH
// Frame layout
`define DFD_FRAME_W 24
`define DFD_RW_BIT 23
`define DFD_DEV_HI 22
`define DFD_DEV_LO 21
`define DFD_REG_HI 20
`define DFD_REG_LO 18
`define DFD_CH_HI 17
`define DFD_CH_LO 16
`define DFD_CTL_HI 15
`define DFD_CTL_LO 13
// Register-select codes
`define DFD_SEL_DATA 3'h0
`define DFD_SEL_GAIN 3'h2
`define DFD_SEL_GAIN_ALL 3'h3
`define DFD_SEL_OFS 3'h4
`define DFD_SEL_OFS_ALL 3'h5
`define DFD_SEL_CLR 3'h6
`define DFD_SEL_CTL 3'h7
// Reset values
`define DFD_GAIN_RST 16'hFFFF
`define DFD_OFS_RST 16'h8000
`define DFD_CLR_RST 16'h0000
`define DFD_DATA_RST 16'h0000
`endif

/* File: rtl/dfd_frame_decode.sv */
// Purpose: Decodes serial write frames into per-channel trim and clear registers
// Assumes: Serial link on its own clock; address straps and clear pin are async
// Notes: Control frames are forwarded as a one-cycle write strobe
//
// Contract
// - Select 010 writes addressed channel gain
// - Select 011 writes gain on all channels
// - Gain straight binary, resets to FFFF
// - Select 100 writes addressed channel offset
// - Select 101 writes offset on all channels
// - Offset straight binary, zero most negative
// - Offset resets to 8000, no adjustment
// - Select 110 writes addressed channel clear code
// - Per-channel clear enable under software control
// - Clear code resets to 0000
// - Select 111 routes to control registers
// - Three control-select bits under channel bits
// - 24-bit frame: rw, device, select, channel, data
// - Channel bits pick A-D, else ignored
// - Select 000 writes addressed channel data
// - Act only when device bits match straps
`include "dfd_defines.svh"
module dfd_frame_decode
  import dfd_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic address_strap_hi,
  input wire logic address_strap_lo,
  input wire logic clear_pin,
  output logic [16*CHANNELS-1:0] gain_trim,
  output logic [16*CHANNELS-1:0] offset_trim,
  output logic [16*CHANNELS-1:0] clear_value,
  output logic [16*CHANNELS-1:0] dac_data,
  output logic [CHANNELS-1:0] clear_active,
  output logic ctl_wr,
  output logic [2:0] ctl_select,
  output logic [1:0] ctl_channel,
  output logic [12:0] ctl_data,
  output logic frame_seen
);
  ////////////////////////////////////////////////////////////////////////////
  // Link side
  dfd_xfer_if xfer ();
  dfd_link_shift u_link (
    .sclk(sclk),
    .sync_n(sync_n),
    .sdin(sdin),
    .xfer(xfer.link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Crossing of toggle, straps and clear pin
  logic [2:0] tog_sync_reg;
  logic [2:0] tog_sync_next;
  logic [1:0] strap_s1_reg;
  logic [1:0] strap_s2_reg;
  logic [1:0] clr_sync_reg;
  logic [1:0] strap_s1_next;
  logic [1:0] strap_s2_next;
  logic [1:0] clr_sync_next;

  // Two-stage synchronisers plus toggle history
  always_comb begin
    tog_sync_next = {tog_sync_reg[1:0], xfer.toggle};
    strap_s1_next = {address_strap_hi, address_strap_lo};
    strap_s2_next = strap_s1_reg;
    clr_sync_next = {clr_sync_reg[0], clear_pin};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tog_sync_reg <= 3'h0;
      strap_s1_reg <= 2'h0;
      strap_s2_reg <= 2'h0;
      clr_sync_reg <= 2'h0;
    end else if (ce) begin
      tog_sync_reg <= tog_sync_next;
      strap_s1_reg <= strap_s1_next;
      strap_s2_reg <= strap_s2_next;
      clr_sync_reg <= clr_sync_next;
    end
  end

  logic frame_evt;
  assign frame_evt = tog_sync_reg[2] ^ tog_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction
  function automatic logic chan_hit(input logic [1:0] sel, input int idx);
    chan_hit = (sel == idx[1:0]);
  endfunction : chan_hit

  dfd_frame_t fr;
  logic fr_write;
  logic fr_mine;
  logic [2:0] fr_sel;
  logic [1:0] fr_ch;
  dfd_word_t fr_data;
  assign fr = xfer.frame; // Stable: toggle seen two stages late
  assign fr_write = ~fr[`DFD_RW_BIT];
  assign fr_mine = (fr[`DFD_DEV_HI:`DFD_DEV_LO] == strap_s2_reg);
  assign fr_sel = fr[`DFD_REG_HI:`DFD_REG_LO];
  assign fr_ch = fr[`DFD_CH_HI:`DFD_CH_LO];
  assign fr_data = fr[15:0];

  logic take;
  assign take = frame_evt & fr_write & fr_mine;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel register file
  logic [CHANNELS-1:0] clr_en_reg;
  logic [CHANNELS-1:0] clr_en_next;
  logic [CHANNELS-1:0] clr_act_reg;
  logic [CHANNELS-1:0] clr_act_next;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      dfd_word_t gain_reg, gain_next;
      dfd_word_t ofs_reg, ofs_next;
      dfd_word_t clrv_reg, clrv_next;
      dfd_word_t data_reg, data_next;
      logic hit;
      assign hit = chan_hit(fr_ch, g);

      // Decode register select into this channel
      always_comb begin
        gain_next = gain_reg;
        ofs_next = ofs_reg;
        clrv_next = clrv_reg;
        data_next = data_reg;
        if (take) begin
          unique case (fr_sel)
            `DFD_SEL_DATA: if (hit) data_next = fr_data;
            `DFD_SEL_GAIN: if (hit) gain_next = fr_data;
            `DFD_SEL_GAIN_ALL: gain_next = fr_data;
            `DFD_SEL_OFS: if (hit) ofs_next = fr_data;
            `DFD_SEL_OFS_ALL: ofs_next = fr_data;
            `DFD_SEL_CLR: if (hit) clrv_next = fr_data;
            default: ;
          endcase
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          gain_reg <= `DFD_GAIN_RST;
          ofs_reg <= `DFD_OFS_RST;
          clrv_reg <= `DFD_CLR_RST;
          data_reg <= `DFD_DATA_RST;
        end else if (ce) begin
          gain_reg <= gain_next;
          ofs_reg <= ofs_next;
          clrv_reg <= clrv_next;
          data_reg <= data_next;
        end
      end

      // Offset and gain exported as raw straight-binary codes
      assign gain_trim[16*g +: 16] = gain_reg;
      assign offset_trim[16*g +: 16] = ofs_reg;
      assign clear_value[16*g +: 16] = clrv_reg;
      assign dac_data[16*g +: 16] = data_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Clear enables: per-channel software register via control frames
  // Control select 100 (software register) carries enables in data[3:0]
  logic ctl_take;
  assign ctl_take = take & (fr_sel == `DFD_SEL_CTL);

  always_comb begin
    clr_en_next = clr_en_reg;
    if (ctl_take && fr[`DFD_CTL_HI:`DFD_CTL_LO] == 3'h4) begin
      clr_en_next = fr_data[CHANNELS-1:0];
    end
    clr_act_next = clr_en_reg & {CHANNELS{clr_sync_reg[1]}};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clr_en_reg <= '0;
      clr_act_reg <= '0;
    end else if (ce) begin
      clr_en_reg <= clr_en_next;
      clr_act_reg <= clr_act_next;
    end
  end
  assign clear_active = clr_act_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control-register forward strobe
  logic ctl_wr_reg;
  logic [2:0] ctl_sel_reg;
  logic [1:0] ctl_ch_reg;
  logic [12:0] ctl_data_reg;
  logic seen_reg;
  logic ctl_wr_next;
  logic [2:0] ctl_sel_next;
  logic [1:0] ctl_ch_next;
  logic [12:0] ctl_data_next;
  logic seen_next;

  always_comb begin
    ctl_wr_next = ctl_take;
    ctl_sel_next = ctl_sel_reg;
    ctl_ch_next = ctl_ch_reg;
    ctl_data_next = ctl_data_reg;
    seen_next = frame_evt & fr_mine;
    if (ctl_take) begin
      ctl_sel_next = fr[`DFD_CTL_HI:`DFD_CTL_LO];
      ctl_ch_next = fr_ch;
      ctl_data_next = fr[12:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_wr_reg <= 1'b0;
      ctl_sel_reg <= 3'h0;
      ctl_ch_reg <= 2'h0;
      ctl_data_reg <= 13'h0000;
      seen_reg <= 1'b0;
    end else if (ce) begin
      ctl_wr_reg <= ctl_wr_next;
      ctl_sel_reg <= ctl_sel_next;
      ctl_ch_reg <= ctl_ch_next;
      ctl_data_reg <= ctl_data_next;
      seen_reg <= seen_next;
    end
  end

  assign ctl_wr = ctl_wr_reg;
  assign ctl_select = ctl_sel_reg;
  assign ctl_channel = ctl_ch_reg;
  assign ctl_data = ctl_data_reg;
  assign frame_seen = seen_reg;
endmodule : dfd_frame_decode

/* File: rtl/dfd_link_shift.sv */
// Purpose: Shifts serial frames on the link clock and publishes each full frame
// Assumes: Frame select is low during a frame; data sampled on falling link edge
// Notes: Link clock may stop outside frames; frame end is taken at select rise
`include "dfd_defines.svh"
module dfd_link_shift
  import dfd_pkg::*;
(
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  dfd_xfer_if.link xfer
);
  logic [23:0] shift_reg;
  logic [4:0] count_reg;
  logic [23:0] shift_next;
  logic [4:0] count_next;

  // Shift while frame select is low
  always_comb begin
    shift_next = {shift_reg[22:0], sdin};
    count_next = (count_reg == 5'(`DFD_FRAME_W)) ? count_reg : count_reg + 5'h01;
  end

  // Bit counter clears asynchronously at frame-select rise and holds at zero while select is high
  always_ff @(negedge sclk or posedge sync_n) begin
    if (sync_n) begin
      count_reg <= 5'h00;
    end else begin
      shift_reg <= shift_next;
      count_reg <= count_next;
    end
  end

  // No reset on the link side; toggle starts equal to the core history
  logic toggle_reg = 1'b0;
  logic [23:0] frame_reg = 24'h000000;
  logic toggle_next;
  logic [23:0] frame_next;

  // Frame closes at select rise; publish only full frames
  always_comb begin
    toggle_next = toggle_reg;
    frame_next = frame_reg;
    if (count_reg == 5'(`DFD_FRAME_W)) begin
      frame_next = shift_reg;
      toggle_next = ~toggle_reg;
    end
  end

  // Publish register, clocked by the frame-select rise
  always_ff @(posedge sync_n) begin
    frame_reg <= frame_next;
    toggle_reg <= toggle_next;
  end

  assign xfer.frame = frame_reg;
  assign xfer.toggle = toggle_reg;
endmodule : dfd_link_shift

/* File: rtl/dfd_pkg.sv */
// Purpose: Types shared by the frame decoder files
// Assumes: Constants come from dfd_defines.svh
// Notes: Frame word handed across the clock boundary
package dfd_pkg;
  typedef logic [23:0] dfd_frame_t;
  typedef logic [15:0] dfd_word_t;
  typedef enum logic [2:0] {
    DFD_IDLE = 3'b001,
    DFD_SYNC = 3'b010,
    DFD_DONE = 3'b100
  } dfd_state_t;
endpackage : dfd_pkg

/* File: rtl/dfd_xfer_if.sv */
// Purpose: Carries a finished frame from the link shifter to the decoder
// Assumes: frame is stable while toggle differs from the last seen value
// Notes: Toggle handshake, one frame in flight
interface dfd_xfer_if;
  import dfd_pkg::*;
  dfd_frame_t frame;
  logic toggle;
  modport link (output frame, output toggle);
  modport core (input frame, input toggle);
endinterface : dfd_xfer_if
